/* pkg/thtrig_defines.svh */
`ifndef THTRIG_DEFINES_SVH
`define THTRIG_DEFINES_SVH

// clock and gate timing
`define THT_CLK_HZ 20000000
`define THT_GATE_STEP_MS 50
`define THT_GATE_STEP_CYCLES ((`THT_CLK_HZ / 1000) * `THT_GATE_STEP_MS)
`define THT_GATE_UNITS_MIN 11'h001
`define THT_GATE_UNITS_MAX 11'h7CF

// value ranges
`define THT_FREQ_THR_MAX 14'h270F
`define THT_PULSE_MAX 17'h1FFFF
`define THT_ANALOG_FULL 10'h3E8
`define THT_GAIN_MAX 11'h3E8
`define THT_OFFSET_MAX 11'sh3E7
`define THT_OFFSET_MIN (-11'sh3E7)
`define THT_ATHR_MAX 16'sh4E16
`define THT_ATHR_MIN (-16'sh4E16)
`define THT_GAIN_DIV 24'sh000064

// reset values
`define THT_RST_COUNT 20'h00000
`define THT_RST_UNITS 11'h000
`define THT_RST_PULSES 17'h00000
`define THT_RST_SCALED 16'sh0000
`define THT_RST_DIFF 17'sh00000

`endif

/* pkg/thtrig_pkg.sv */
package thtrig_pkg;

    typedef struct packed {
        logic [19:0] step_cnt;
        logic [10:0] unit_cnt;
        logic [16:0] pulse_cnt;
        logic [16:0] pulse_total;
        logic cnt_prev;
        logic gate_done;
        logic freq_sw;
        logic signed [15:0] trig_scaled;
        logic trig_sw;
        logic signed [15:0] cmp_scaled_x;
        logic signed [15:0] cmp_scaled_y;
        logic signed [16:0] cmp_diff;
        logic cmp_sw;
    } thtrig_state_t;

endpackage : thtrig_pkg

/* core/thtrig_top.sv */
`timescale 1ns/100ps
`include "thtrig_defines.svh"

// Contract
// - count pulses on the count input across each gate interval; total is the frequency.
// - frequency output goes high when total exceeds both on and off thresholds.
// - frequency output goes low when total equals or drops below off threshold.
// - frequency thresholds cover the whole range 0 to 9999.
// - gate interval settable from 50 ms to 99.95 s.
// - reported measurement is the raw pulse total of one gate interval.
// - analog readings use the linear scale 0 to 1000 for 0 to 10 V.
// - gain in percent up to 1000, signed offset up to magnitude 999.
// - analog trigger thresholds are signed, magnitude up to 19990, against scaled value.
// - analog trigger adds offset to reading first, then multiplies by gain.
// - analog trigger output set when scaled value rises above on threshold.
// - analog trigger output cleared when scaled value falls below off threshold.
// - comparator output one when scaled difference of two inputs exceeds threshold.
// - comparator offsets and scales both inputs, subtracts, clears output otherwise.

module thtrig_top #(
    parameter int unsigned GATE_STEP_CYCLES = `THT_GATE_STEP_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,

    // frequency trigger
    input wire logic count_in,
    input wire logic [13:0] freq_on_threshold,
    input wire logic [13:0] freq_off_threshold,
    input wire logic [10:0] gate_units,
    output logic [16:0] measured_pulse_total,
    output logic gate_done,
    output logic freq_switch,

    // analog trigger
    input wire logic [9:0] analog_channel_one,
    input wire logic [10:0] trig_gain,
    input wire logic signed [10:0] trig_offset,
    input wire logic signed [15:0] trig_on_threshold,
    input wire logic signed [15:0] trig_off_threshold,
    output logic signed [15:0] trig_scaled,
    output logic trig_switch,

    // analog comparator
    input wire logic [9:0] analog_input_x,
    input wire logic [9:0] analog_input_y,
    input wire logic [10:0] cmp_gain,
    input wire logic signed [10:0] cmp_offset,
    input wire logic signed [16:0] cmp_threshold,
    output logic signed [16:0] cmp_diff,
    output logic cmp_switch
);

    // ********************************************************************
    // range limiting helpers
    // ********************************************************************

    // readings above full scale are pinned so scaling never exceeds its range
    function automatic logic [9:0] thtrig_clip_analog(input logic [9:0] raw);
        logic [9:0] res;
        res = raw;
        if (raw > `THT_ANALOG_FULL) begin
            res = `THT_ANALOG_FULL;
        end
        return res;
    endfunction : thtrig_clip_analog

    function automatic logic [10:0] thtrig_clip_gain(input logic [10:0] raw);
        logic [10:0] res;
        res = raw;
        if (raw > `THT_GAIN_MAX) begin
            res = `THT_GAIN_MAX;
        end
        return res;
    endfunction : thtrig_clip_gain

    function automatic logic signed [10:0] thtrig_clip_offset(input logic signed [10:0] raw);
        logic signed [10:0] res;
        res = raw;
        if (raw > `THT_OFFSET_MAX) begin
            res = `THT_OFFSET_MAX;
        end else if (raw < `THT_OFFSET_MIN) begin
            res = `THT_OFFSET_MIN;
        end
        return res;
    endfunction : thtrig_clip_offset

    function automatic logic signed [15:0] thtrig_clip_athr(input logic signed [15:0] raw);
        logic signed [15:0] res;
        res = raw;
        if (raw > `THT_ATHR_MAX) begin
            res = `THT_ATHR_MAX;
        end else if (raw < `THT_ATHR_MIN) begin
            res = `THT_ATHR_MIN;
        end
        return res;
    endfunction : thtrig_clip_athr

    function automatic logic [13:0] thtrig_clip_fthr(input logic [13:0] raw);
        logic [13:0] res;
        res = raw;
        if (raw > `THT_FREQ_THR_MAX) begin
            res = `THT_FREQ_THR_MAX;
        end
        return res;
    endfunction : thtrig_clip_fthr

    // ********************************************************************
    // offset then gain scaling
    // ********************************************************************

    // worst case (1000 + 999) * 1000 = 1999000 fits a 24-bit signed product;
    // the quotient by 100 stays within +-19990 and so within 16 bits
    function automatic logic signed [15:0] thtrig_scale(
        input logic [9:0] reading,
        input logic signed [10:0] offset,
        input logic [10:0] gain
    );
        logic signed [11:0] sum;
        logic signed [23:0] prod;
        logic signed [23:0] quot;
        sum = $signed({2'b00, reading}) + 12'(offset);
        prod = 24'(sum) * $signed({13'h0000, gain});
        quot = prod / `THT_GAIN_DIV;
        return quot[15:0];
    endfunction : thtrig_scale

    // ********************************************************************
    // conditioned settings
    // ********************************************************************

    logic [9:0] ain_trig;
    logic [9:0] ain_x;
    logic [9:0] ain_y;
    logic [10:0] gain_trig;
    logic [10:0] gain_cmp;
    logic signed [10:0] offs_trig;
    logic signed [10:0] offs_cmp;
    logic signed [15:0] thr_on_trig;
    logic signed [15:0] thr_off_trig;
    logic [13:0] thr_on_freq;
    logic [13:0] thr_off_freq;
    logic [10:0] gate_len;
    logic [19:0] step_last;

    assign ain_trig = thtrig_clip_analog(analog_channel_one);
    assign ain_x = thtrig_clip_analog(analog_input_x);
    assign ain_y = thtrig_clip_analog(analog_input_y);
    assign gain_trig = thtrig_clip_gain(trig_gain);
    assign gain_cmp = thtrig_clip_gain(cmp_gain);
    assign offs_trig = thtrig_clip_offset(trig_offset);
    assign offs_cmp = thtrig_clip_offset(cmp_offset);
    assign thr_on_trig = thtrig_clip_athr(trig_on_threshold);
    assign thr_off_trig = thtrig_clip_athr(trig_off_threshold);
    assign thr_on_freq = thtrig_clip_fthr(freq_on_threshold);
    assign thr_off_freq = thtrig_clip_fthr(freq_off_threshold);
    assign step_last = 20'(GATE_STEP_CYCLES - 1);

    // gate length in 50 ms steps, pinned to 1..1999 (50 ms to 99.95 s)
    always_comb begin
        gate_len = gate_units;
        if (gate_units < `THT_GATE_UNITS_MIN) begin
            gate_len = `THT_GATE_UNITS_MIN;
        end else if (gate_units > `THT_GATE_UNITS_MAX) begin
            gate_len = `THT_GATE_UNITS_MAX;
        end
    end

    // ********************************************************************
    // state update
    // ********************************************************************

    thtrig_pkg::thtrig_state_t st_q;
    thtrig_pkg::thtrig_state_t st_d;

    logic pulse_edge;
    logic step_end;
    logic gate_end;
    logic [16:0] pulse_final;

    assign pulse_edge = count_in & ~st_q.cnt_prev;
    assign step_end = (st_q.step_cnt >= step_last);
    // a changed gate length takes effect at once; a shortened gate ends at the end of the current step
    assign gate_end = step_end && (st_q.unit_cnt >= (gate_len - 11'h001));

    // an edge in the closing cycle belongs to the interval that is closing
    always_comb begin
        pulse_final = st_q.pulse_cnt;
        if (pulse_edge && (st_q.pulse_cnt != `THT_PULSE_MAX)) begin
            pulse_final = st_q.pulse_cnt + 17'h00001;
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.cnt_prev = count_in;
        st_d.gate_done = 1'b0;

        // gate timebase
        if (step_end) begin
            st_d.step_cnt = `THT_RST_COUNT;
            st_d.unit_cnt = st_q.unit_cnt + 11'h001;
        end else begin
            st_d.step_cnt = st_q.step_cnt + 20'h00001;
        end

        if (gate_end) begin
            st_d.unit_cnt = `THT_RST_UNITS;
            st_d.pulse_cnt = `THT_RST_PULSES;
            st_d.pulse_total = pulse_final;
            st_d.gate_done = 1'b1;
            // switching judged on the interval just closed, never mid-gate
            if ((pulse_final > {3'b000, thr_on_freq}) && (pulse_final > {3'b000, thr_off_freq})) begin
                st_d.freq_sw = 1'b1;
            end else if (pulse_final <= {3'b000, thr_off_freq}) begin
                st_d.freq_sw = 1'b0;
            end
        end else begin
            st_d.pulse_cnt = pulse_final;
        end

        // analog trigger: one cycle of scaling, comparison on the registered value
        st_d.trig_scaled = thtrig_scale(ain_trig, offs_trig, gain_trig);
        if (st_q.trig_scaled > thr_on_trig) begin
            st_d.trig_sw = 1'b1;
        end else if (st_q.trig_scaled < thr_off_trig) begin
            st_d.trig_sw = 1'b0;
        end

        // analog comparator: scale both, subtract, then compare
        st_d.cmp_scaled_x = thtrig_scale(ain_x, offs_cmp, gain_cmp);
        st_d.cmp_scaled_y = thtrig_scale(ain_y, offs_cmp, gain_cmp);
        st_d.cmp_diff = 17'(st_q.cmp_scaled_x) - 17'(st_q.cmp_scaled_y);
        st_d.cmp_sw = (st_q.cmp_diff > cmp_threshold);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q.step_cnt <= `THT_RST_COUNT;
            st_q.unit_cnt <= `THT_RST_UNITS;
            st_q.pulse_cnt <= `THT_RST_PULSES;
            st_q.pulse_total <= `THT_RST_PULSES;
            st_q.cnt_prev <= 1'b0;
            st_q.gate_done <= 1'b0;
            st_q.freq_sw <= 1'b0;
            st_q.trig_scaled <= `THT_RST_SCALED;
            st_q.trig_sw <= 1'b0;
            st_q.cmp_scaled_x <= `THT_RST_SCALED;
            st_q.cmp_scaled_y <= `THT_RST_SCALED;
            st_q.cmp_diff <= `THT_RST_DIFF;
            st_q.cmp_sw <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************

    assign measured_pulse_total = st_q.pulse_total;
    assign gate_done = st_q.gate_done;
    assign freq_switch = st_q.freq_sw;
    assign trig_scaled = st_q.trig_scaled;
    assign trig_switch = st_q.trig_sw;
    assign cmp_diff = st_q.cmp_diff;
    assign cmp_switch = st_q.cmp_sw;

endmodule : thtrig_top

/* tb/thtrig_assertions.sv */
`timescale 1ns/100ps
// ****
// switch output checks
// ****
module thtrig_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // frequency trigger
    input wire logic [13:0] freq_on_threshold,
    input wire logic [13:0] freq_off_threshold,
    input wire logic [16:0] measured_pulse_total,
    input wire logic gate_done,
    input wire logic freq_switch,
    // analog trigger and comparator
    input wire logic signed [15:0] trig_on_threshold,
    input wire logic signed [15:0] trig_off_threshold,
    input wire logic signed [15:0] trig_scaled,
    input wire logic trig_switch,
    input wire logic signed [16:0] cmp_threshold,
    input wire logic signed [16:0] cmp_diff,
    input wire logic cmp_switch
);
    logic f_hi;
    logic f_lo;
    assign f_hi = (measured_pulse_total > freq_on_threshold) && (measured_pulse_total > freq_off_threshold);
    assign f_lo = measured_pulse_total <= freq_off_threshold;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a threshold step may reach the switch one stage earlier than the scaled value
    sequence s_tst; $stable(trig_on_threshold) && $stable(trig_off_threshold); endsequence
    sequence s_close; gate_done; endsequence
    property p_hold; !gate_done |-> $stable(freq_switch) && $stable(measured_pulse_total); endproperty
    a_hold: assert property (p_hold) else $error("frequency output moved mid gate");
    property p_fon; s_close ##0 f_hi |-> freq_switch; endproperty
    a_fon: assert property (p_fon) else $error("frequency output not set");
    property p_foff; s_close ##0 f_lo |-> !freq_switch; endproperty
    a_foff: assert property (p_foff) else $error("frequency output not cleared");
    property p_ton; s_tst ##0 (trig_scaled > trig_on_threshold) |=> trig_switch; endproperty
    a_ton: assert property (p_ton) else $error("trigger output not set");
    property p_toff; s_tst ##0 (trig_scaled <= trig_on_threshold && trig_scaled < trig_off_threshold) |=> !trig_switch;
    endproperty
    a_toff: assert property (p_toff) else $error("trigger output not cleared");
    property p_thold; s_tst ##0 (trig_scaled <= trig_on_threshold && trig_scaled >= trig_off_threshold)
        |=> $stable(trig_switch); endproperty
    a_thold: assert property (p_thold) else $error("trigger output moved inside band");
    property p_con; $stable(cmp_threshold) && cmp_diff > cmp_threshold |=> cmp_switch; endproperty
    a_con: assert property (p_con) else $error("comparator output not set");
    property p_coff; $stable(cmp_threshold) && cmp_diff <= cmp_threshold |=> !cmp_switch; endproperty
    a_coff: assert property (p_coff) else $error("comparator output not cleared");
endmodule : thtrig_assertions

/* tb/thtrig_pulse_src.sv */
`timescale 1ns/100ps
// ****
// pulse source: n pulses, one cycle high and one low
// ****
module thtrig_pulse_src (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request
    input wire logic start,
    input wire logic [5:0] n,
    // pulse line
    output logic count_in
);
    logic [5:0] rem_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            rem_q <= 6'h00;
            count_in <= 1'b0;
        end else if (start) begin
            rem_q <= n;
        end else if (count_in) begin
            count_in <= 1'b0;
            rem_q <= rem_q - 6'h01;
        end else if (rem_q != 6'h00) begin
            count_in <= 1'b1;
        end
    end
endmodule : thtrig_pulse_src

/* tb/thtrig_tb_top.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %0d got %0d", n, e, g); end end
module thtrig_tb_top;
    logic clk, count_in, gate_done, freq_switch, trig_switch, cmp_switch;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [5:0] np = 6'h00;
    logic [13:0] freq_on_threshold = 14'h0000, freq_off_threshold = 14'h0000;
    logic [10:0] gate_units = 11'h014, trig_gain = 11'h000, cmp_gain = 11'h000;
    logic signed [10:0] trig_offset = 11'sh000, cmp_offset = 11'sh000;
    logic signed [15:0] trig_on_threshold = 16'sh0000, trig_off_threshold = 16'sh0000, trig_scaled;
    logic signed [16:0] cmp_threshold = 17'sh00000, cmp_diff;
    logic [9:0] analog_channel_one = 10'h000, analog_input_x = 10'h000, analog_input_y = 10'h000;
    logic [16:0] measured_pulse_total;
    logic [31:0] seed = 32'h0000845F;
    int bad_count = 0, cmp_count = 0, w, r, o, gn, on, of, x, y, co2, cg2, th, d;
    bit msw = 1'b0, mt = 1'b0;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // short gate step keeps the run small: one step is 4 cycles
    thtrig_top #(.GATE_STEP_CYCLES(4)) dut (.clk, .rst, .count_in, .freq_on_threshold, .freq_off_threshold,
        .gate_units, .measured_pulse_total, .gate_done, .freq_switch, .analog_channel_one, .trig_gain,
        .trig_offset, .trig_on_threshold, .trig_off_threshold, .trig_scaled, .trig_switch, .analog_input_x,
        .analog_input_y, .cmp_gain, .cmp_offset, .cmp_threshold, .cmp_diff, .cmp_switch);
    thtrig_pulse_src u_src (.clk, .rst, .start, .n(np), .count_in);
    function automatic int rnd(int m);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed % m);
    endfunction : rnd
    function automatic int sc(int a, int b, int c);
        return ((a + b) * c) / 100;
    endfunction : sc
    function automatic bit fx(int t, int hi, int lo, bit p);
        if (t > hi && t > lo) return 1'b1;
        if (t <= lo) return 1'b0;
        return p;
    endfunction : fx
    function automatic bit tx(int v, int hi, int lo, bit p);
        if (v > hi) return 1'b1;
        if (v < lo) return 1'b0;
        return p;
    endfunction : tx
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic waitg();
        w = 0;
        do begin
            @(posedge clk);
            #1;
            w++;
        end while (gate_done !== 1'b1 && w < 9000);
        if (w >= 9000) bad_count++;
    endtask : waitg
    task automatic fgate(int hi, int lo, int n);
        @(posedge clk);
        freq_on_threshold <= 14'(hi);
        freq_off_threshold <= 14'(lo);
        np <= 6'(n);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        waitg();
        msw = fx(n, hi, lo, msw);
        `CHK("total", n, measured_pulse_total)
        `CHK("fsw", msw, freq_switch)
    endtask : fgate
    task automatic gper(int g, int ex);
        @(posedge clk);
        gate_units <= 11'(g);
        waitg();
        waitg();
        `CHK("gate len", ex, w)
    endtask : gper
    initial begin
        #2000000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        waitg();
        `CHK("first gate", 80, w)
        fgate(10, 5, 11);
        fgate(10, 5, 7);
        fgate(10, 5, 5);
        fgate(3, 8, 8);
        fgate(3, 8, 9);
        fgate(0, 0, 0);
        fgate(20, 0, 25);
        fgate(9999, 0, 30);
        fgate(9999, 9999, 30);
        for (int i = 0; i < 6; i++) fgate(rnd(40), rnd(40), rnd(31));
        for (int i = 0; i < 40; i++) begin
            r = rnd(1001);
            o = rnd(1999) - 999;
            gn = rnd(1001);
            on = rnd(39981) - 19990;
            of = rnd(39981) - 19990;
            if (i < 2) begin
                r = 1000;
                o = 999;
                gn = 1000;
                on = 19989 + i;
                of = i ? 19990 : of;
            end
            x = rnd(1001);
            y = rnd(1001);
            co2 = rnd(1999) - 999;
            cg2 = rnd(1001);
            d = sc(x, co2, cg2) - sc(y, co2, cg2);
            th = (i % 3 == 0) ? d : rnd(4001) - 2000;
            @(posedge clk);
            analog_channel_one <= 10'(r);
            trig_offset <= 11'(o);
            trig_gain <= 11'(gn);
            trig_on_threshold <= 16'(on);
            trig_off_threshold <= 16'(of);
            analog_input_x <= 10'(x);
            analog_input_y <= 10'(y);
            cmp_offset <= 11'(co2);
            cmp_gain <= 11'(cg2);
            cmp_threshold <= 17'(th);
            repeat (4) @(posedge clk);
            #1;
            mt = tx(sc(r, o, gn), on, of, mt);
            `CHK("scaled", sc(r, o, gn), trig_scaled)
            `CHK("tsw", mt, trig_switch)
            `CHK("diff", d, cmp_diff)
            `CHK("csw", d > th, cmp_switch)
        end
        gper(0, 4);
        gper(1, 4);
        gper(3, 12);
        gper(2000, 7996);
        tally_and_finish();
    end
endmodule : thtrig_tb_top
bind thtrig_top thtrig_assertions u_chk (.clk, .rst, .freq_on_threshold, .freq_off_threshold, .measured_pulse_total,
    .gate_done, .freq_switch, .trig_on_threshold, .trig_off_threshold, .trig_scaled, .trig_switch, .cmp_threshold,
    .cmp_diff, .cmp_switch);
